/* dv/iplr_arb_model.sv */
// Purpose: Arbitration side model fed by the priority level registers
// Assumes: Levels are two bits per source, enable high means unmasked
// Notes: Flags any level above two or a level left on a masked source
`timescale 1ns/1ps
module iplr_arb_model import iplr_pkg::*; (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Requests from the register block
	input wire logic [IPLR_NUM_SRC-1:0] i_src_req_en,
	input wire logic [2*IPLR_NUM_SRC-1:0] i_src_level,
	// Arbitration view
	output logic [1:0] o_top_level,
	output logic o_bad_level
);
	logic bad_ff;
	logic nxt_bad;

	// Highest level among unmasked sources
	always_comb begin
		o_top_level = 2'h0;
		nxt_bad = bad_ff;
		for (int k = 0; k < IPLR_NUM_SRC; k++) begin
			if (i_src_req_en[k] && i_src_level[2*k+:2] > o_top_level) begin
				o_top_level = i_src_level[2*k+:2];
			end
			if (i_src_level[2*k+:2] > IPLR_LEVEL_MAX) begin
				nxt_bad = 1'b1;
			end
			if (!i_src_req_en[k] && i_src_level[2*k+:2] != 2'h0) begin
				nxt_bad = 1'b1;
			end
		end
	end

	// Sticky so a one-cycle glitch is not lost
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			bad_ff <= 1'b0;
		end else begin
			bad_ff <= nxt_bad;
		end
	end
	assign o_bad_level = bad_ff;
endmodule

/* dv/iplr_regs_tb.sv */
// Purpose: Self-checking bench for the priority level registers
// Assumes: Zero wait state APB slave, outputs one cycle behind registers
// Notes: Expected register images are kept here and masked per register
`timescale 1ns/1ps
module iplr_regs_tb import iplr_pkg::*;;
	logic clk;
	logic rst;
	logic psel;
	logic penable;
	logic pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [3:0] pstrb;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic [IPLR_NUM_SRC-1:0] req_en;
	logic [2*IPLR_NUM_SRC-1:0] level;
	logic [1:0] top_level;
	logic bad_level;
	logic [15:0] img [6:9];
	int mismatches;
	int check_count;

	iplr_regs #(.ADDR_W(12)) iplr_regs_i (.i_clk(clk), .i_sys_rst(rst), .i_psel(psel),
		.i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
		.i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr),
		.o_src_req_en(req_en), .o_src_level(level));
	iplr_arb_model iplr_arb_model_i (.i_clk(clk), .i_sys_rst(rst), .i_src_req_en(req_en),
		.i_src_level(level), .o_top_level(top_level), .o_bad_level(bad_level));

	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	task automatic summarize();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask

	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		check_count++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch at %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	function automatic logic [15:0] wmask(input int idx);
		case (idx)
			6: return IPLR_MASK_REG6;
			7: return IPLR_MASK_REG7;
			8: return IPLR_MASK_REG8;
			default: return IPLR_MASK_REG9;
		endcase
	endfunction

	// One transfer, then one idle cycle so psel is never reassigned in a step
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
		input logic [3:0] st, output logic [31:0] rd, output logic err);
		int n;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= wd;
		pstrb <= st;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 16);
		if (n >= 16) begin
			mismatches++;
			summarize();
		end
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clk);
	endtask

	// Write through lanes 0 and 1, track the image, read back
	task automatic wr_rd(input int idx, input logic [15:0] d, input logic [3:0] st);
		logic [31:0] rd;
		logic err;
		logic [15:0] nv;
		nv = img[idx];
		if (st[0]) nv[7:0] = d[7:0];
		if (st[1]) nv[15:8] = d[15:8];
		img[idx] = nv & wmask(idx);
		apb(1'b1, 12'(idx * 4), {~d, d}, st, rd, err);
		check({63'h0, err}, 64'h0);
		apb(1'b0, 12'(idx * 4), 32'h0, 4'h0, rd, err);
		check({32'h0, rd}, {48'h0, img[idx]});
	endtask

	// Expected source outputs from the images
	task automatic check_src();
		logic [49:0] codes;
		logic [24:0] en;
		logic [49:0] lv;
		logic [1:0] top;
		repeat (2) @(posedge clk);
		codes = {img[9], img[8][15:12], img[8][9:0], img[7], img[6][3:0]};
		top = 2'h0;
		for (int k = 0; k < IPLR_NUM_SRC; k++) begin
			en[k] = codes[2*k+:2] != 2'h0;
			lv[2*k+:2] = en[k] ? codes[2*k+:2] - 2'h1 : 2'h0;
			if (en[k] && lv[2*k+:2] > top) top = lv[2*k+:2];
		end
		check({39'h0, req_en}, {39'h0, en});
		check({14'h0, level}, {14'h0, lv});
		check({62'h0, top_level}, {62'h0, top});
	endtask

	task automatic reset_check();
		logic [31:0] rd;
		logic err;
		rst <= 1'b1;
		repeat (8) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		for (int i = 6; i <= 9; i++) begin
			img[i] = IPLR_RESET_VAL;
			apb(1'b0, 12'(i * 4), 32'h0, 4'h0, rd, err);
			check({32'h0, rd}, 64'h0);
		end
		check_src();
	endtask

	initial begin
		logic [31:0] rd;
		logic err;
		logic [11:0] bad_addr [3];
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'h0;
		mismatches = 0;
		check_count = 0;
		void'($urandom(10));
		bad_addr = '{12'h028, 12'h01d, 12'h014};
		reset_check();
		// Every code in every field, reserved bits written with the same code
		for (int c = 0; c < 4; c++) begin
			for (int i = 6; i <= 9; i++) begin
				wr_rd(i, {8{c[1:0]}}, 4'h3);
			end
			check_src();
		end
		// Random words and strobes
		for (int t = 0; t < 60; t++) begin
			wr_rd(6 + ($urandom % 4), 16'($urandom), 4'($urandom));
			check_src();
		end
		// Unmapped and unaligned places refuse and leave registers alone
		for (int j = 0; j < 3; j++) begin
			apb(1'b1, bad_addr[j], 32'hffff, 4'hf, rd, err);
			check({63'h0, err}, 64'h1);
			apb(1'b0, bad_addr[j], 32'h0, 4'h0, rd, err);
			check({31'h0, err, rd}, {32'h1, 32'h0});
		end
		check_src();
		// Reset in mid-run with everything programmed
		for (int i = 6; i <= 9; i++) begin
			wr_rd(i, 16'hffff, 4'h3);
		end
		check_src();
		// Sticky flag is looked at before reset clears it
		check({63'h0, bad_level}, 64'h0);
		reset_check();
		check({63'h0, bad_level}, 64'h0);
		summarize();
	end
endmodule

/* rtl/iplr_apb_decode.sv */
// Purpose: Address decode of the priority registers on APB
// Assumes: Word aligned accesses, byte address is index times four
// Notes: Purely combinational, unmapped addresses flag o_mapped low
`timescale 1ns/1ps
module iplr_apb_decode import iplr_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// Bus address
	input wire logic [ADDR_W-1:0] i_paddr,
	// Decode result
	output logic o_sel_reg6,
	output logic o_sel_reg7,
	output logic o_sel_reg8,
	output logic o_sel_reg9,
	output logic o_mapped
);

	function automatic logic [ADDR_W-1:0] byte_addr(input logic [3:0] idx);
		byte_addr = ADDR_W'({idx, 2'b00});
	endfunction

	if (ADDR_W < IPLR_MIN_ADDR_W) begin : g_bad_addr_w
		$error("iplr_apb_decode: address width too small for register map");
	end

	always_comb begin
		o_sel_reg6 = (i_paddr == byte_addr(IPLR_IDX_REG6));
		o_sel_reg7 = (i_paddr == byte_addr(IPLR_IDX_REG7));
		o_sel_reg8 = (i_paddr == byte_addr(IPLR_IDX_REG8));
		o_sel_reg9 = (i_paddr == byte_addr(IPLR_IDX_REG9));
		o_mapped = o_sel_reg6 | o_sel_reg7 | o_sel_reg8 | o_sel_reg9;
	end

endmodule

/* rtl/iplr_level_decode.sv */
// Purpose: Turns two-bit priority codes into request enables and levels
// Assumes: One code per source, packed lowest source first
// Notes: Outputs are registered, one cycle behind the register file
`timescale 1ns/1ps
module iplr_level_decode import iplr_pkg::*; #(
	parameter int NUM_SRC = IPLR_NUM_SRC
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// Packed codes
	input wire logic [2*NUM_SRC-1:0] i_codes,
	// Decoded per source
	output logic [NUM_SRC-1:0] o_req_en,
	output logic [2*NUM_SRC-1:0] o_level
);

	if (NUM_SRC < 1) begin : g_bad_num
		$error("iplr_level_decode: at least one source is needed");
	end

	// Code minus one gives the level, masked code gives zero
	function automatic logic [1:0] decode_level(input logic [1:0] code);
		decode_level = (code == IPLR_CODE_MASKED) ? 2'h0 : 2'(code - IPLR_CODE_LEVEL0);
	endfunction

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_req_en <= '0;
		end else begin
			for (int k = 0; k < NUM_SRC; k++) begin
				o_req_en[k] <= (i_codes[2*k +: 2] != IPLR_CODE_MASKED);
			end
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			o_level <= '0;
		end else begin
			for (int k = 0; k < NUM_SRC; k++) begin
				o_level[2*k +: 2] <= decode_level(i_codes[2*k +: 2]);
			end
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	for (genvar g = 0; g < NUM_SRC; g++) begin : g_chk
		chk_masked_off: assert property (
			i_codes[2*g +: 2] == IPLR_CODE_MASKED |=> !o_req_en[g] && o_level[2*g +: 2] == 2'h0)
			else $error("masked code still enables its source");
		chk_level_decode: assert property (
			i_codes[2*g +: 2] != IPLR_CODE_MASKED |=>
			o_req_en[g] && o_level[2*g +: 2] == 2'($past(i_codes[2*g +: 2]) - IPLR_CODE_LEVEL0))
			else $error("enabled code decoded to the wrong level");
		chk_level_cap: assert property (
			o_level[2*g +: 2] <= IPLR_LEVEL_MAX)
			else $error("source presented above the highest allowed level");
	end

endmodule

/* rtl/iplr_pkg.sv */
// Purpose: Shared constants for the interrupt priority level registers
// Assumes: APB slave with 32-bit data, 16-bit registers in the low half
// Notes: Byte address of a register is four times its index
package iplr_pkg;

	// Register geometry
	localparam int IPLR_REG_W = 16;
	localparam int IPLR_FIELD_W = 2;
	localparam int IPLR_NUM_SRC = 25;
	localparam int IPLR_MIN_ADDR_W = 6;
	localparam logic [IPLR_REG_W-1:0] IPLR_RESET_VAL = 16'h0000;

	// Register indices, byte address is index times four
	localparam logic [3:0] IPLR_IDX_REG6 = 4'h6;
	localparam logic [3:0] IPLR_IDX_REG7 = 4'h7;
	localparam logic [3:0] IPLR_IDX_REG8 = 4'h8;
	localparam logic [3:0] IPLR_IDX_REG9 = 4'h9;

	// Writable bits per register
	localparam logic [IPLR_REG_W-1:0] IPLR_MASK_REG6 = 16'h000f;
	localparam logic [IPLR_REG_W-1:0] IPLR_MASK_REG7 = 16'hffff;
	localparam logic [IPLR_REG_W-1:0] IPLR_MASK_REG8 = 16'hf3ff;
	localparam logic [IPLR_REG_W-1:0] IPLR_MASK_REG9 = 16'hffff;

	// Field codes
	localparam logic [1:0] IPLR_CODE_MASKED = 2'h0;
	localparam logic [1:0] IPLR_CODE_LEVEL0 = 2'h1;
	localparam logic [1:0] IPLR_CODE_LEVEL1 = 2'h2;
	localparam logic [1:0] IPLR_CODE_LEVEL2 = 2'h3;
	localparam logic [1:0] IPLR_LEVEL_MAX = 2'h2;

	// Field positions, sixth register
	localparam int F_DECODER0_INDEX_LEVEL = 2;
	localparam int F_DECODER0_HOME_WDOG_LEVEL = 0;
	// Seventh register
	localparam int F_TIMER_A_CH0_LEVEL = 14;
	localparam int F_TIMER_B_CH3_LEVEL = 12;
	localparam int F_TIMER_B_CH2_LEVEL = 10;
	localparam int F_TIMER_B_CH1_LEVEL = 8;
	localparam int F_TIMER_B_CH0_LEVEL = 6;
	localparam int F_TIMER_C_CH3_LEVEL = 4;
	localparam int F_TIMER_C_CH2_LEVEL = 2;
	localparam int F_TIMER_C_CH1_LEVEL = 0;
	// Eighth register
	localparam int F_SERIAL0_RX_FULL_LEVEL = 14;
	localparam int F_SERIAL0_RX_ERROR_LEVEL = 12;
	localparam int F_REG8_RESERVED = 10;
	localparam int F_SERIAL0_TX_IDLE_LEVEL = 8;
	localparam int F_SERIAL0_TX_EMPTY_LEVEL = 6;
	localparam int F_TIMER_A_CH3_LEVEL = 4;
	localparam int F_TIMER_A_CH2_LEVEL = 2;
	localparam int F_TIMER_A_CH1_LEVEL = 0;
	// Ninth register
	localparam int F_PWM_A_FAULT_LEVEL = 14;
	localparam int F_PWM_B_FAULT_LEVEL = 12;
	localparam int F_PWM_A_RELOAD_LEVEL = 10;
	localparam int F_PWM_B_RELOAD_LEVEL = 8;
	localparam int F_CONV_A_ZERO_CROSS_LEVEL = 6;
	localparam int F_CONV_B_ZERO_CROSS_LEVEL = 4;
	localparam int F_CONV_A_COMPLETE_LEVEL = 2;
	localparam int F_CONV_B_COMPLETE_LEVEL = 0;

	// Source slots in the output vectors
	localparam int S_DECODER0_HOME_WDOG = 0;
	localparam int S_DECODER0_INDEX = 1;
	localparam int S_TIMER_C_CH1 = 2;
	localparam int S_TIMER_C_CH2 = 3;
	localparam int S_TIMER_C_CH3 = 4;
	localparam int S_TIMER_B_CH0 = 5;
	localparam int S_TIMER_B_CH1 = 6;
	localparam int S_TIMER_B_CH2 = 7;
	localparam int S_TIMER_B_CH3 = 8;
	localparam int S_TIMER_A_CH0 = 9;
	localparam int S_TIMER_A_CH1 = 10;
	localparam int S_TIMER_A_CH2 = 11;
	localparam int S_TIMER_A_CH3 = 12;
	localparam int S_SERIAL0_TX_EMPTY = 13;
	localparam int S_SERIAL0_TX_IDLE = 14;
	localparam int S_SERIAL0_RX_ERROR = 15;
	localparam int S_SERIAL0_RX_FULL = 16;
	localparam int S_CONV_B_COMPLETE = 17;
	localparam int S_CONV_A_COMPLETE = 18;
	localparam int S_CONV_B_ZERO_CROSS = 19;
	localparam int S_CONV_A_ZERO_CROSS = 20;
	localparam int S_PWM_B_RELOAD = 21;
	localparam int S_PWM_A_RELOAD = 22;
	localparam int S_PWM_B_FAULT = 23;
	localparam int S_PWM_A_FAULT = 24;

endpackage

/* rtl/iplr_regs.sv */
// Purpose: Interrupt priority level registers six to nine behind APB
// Assumes: Zero wait state APB slave, registers in low 16 bits of the word
// Notes: Read data is captured in the setup cycle so it leaves a flip-flop
//
// Function
// - Code 00 masks a source, 01 10 11 give levels 0 1 2
// - Configured sources reach arbitration only at levels 0 to 2
// - Every priority field resets to the masked code
// - Eighth register bits 11-10 read zero and ignore writes
// - Sixth register bits 3-2 decoder index, bits 1-0 decoder home or watchdog
// - Seventh register bits 15-14 set timer A channel 0 level
// - Seventh register timer B channels 3 to 0 at bits 13-12 down to 7-6
// - Seventh register timer C channels 3 2 1 at bits 5-4 3-2 1-0
// - Eighth register serial 0 rx full 15-14, rx error 13-12
// - Eighth register serial 0 tx idle 9-8, tx empty 7-6
// - Eighth register timer A channels 3 2 1 at bits 5-4 3-2 1-0
// - Ninth register PWM A fault 15-14, PWM B fault 13-12
// - Ninth register PWM A reload 11-10, PWM B reload 9-8
// - Ninth register converter zero crossings 7-6 5-4, completions 3-2 1-0
`timescale 1ns/1ps
module iplr_regs import iplr_pkg::*; #(
	parameter int ADDR_W = 12
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_sys_rst,
	// APB slave
	input wire logic i_psel,
	input wire logic i_penable,
	input wire logic i_pwrite,
	input wire logic [ADDR_W-1:0] i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic [3:0] i_pstrb,
	output logic [31:0] o_prdata,
	output logic o_pready,
	output logic o_pslverr,
	// Per source enable and level towards arbitration
	output logic [IPLR_NUM_SRC-1:0] o_src_req_en,
	output logic [2*IPLR_NUM_SRC-1:0] o_src_level
);

	logic [IPLR_REG_W-1:0] reg6_ff;
	logic [IPLR_REG_W-1:0] priority_reg_timers_ab_c_ff;
	logic [IPLR_REG_W-1:0] priority_reg_serial0_timer_a_ff;
	logic [IPLR_REG_W-1:0] priority_reg_pwm_converter_ff;
	logic [31:0] prdata_ff;
	logic sel_reg6;
	logic sel_reg7;
	logic sel_reg8;
	logic sel_reg9;
	logic mapped;
	logic setup_phase;
	logic access_phase;
	logic wr_en;
	logic [IPLR_REG_W-1:0] rd_value;
	logic [2*IPLR_NUM_SRC-1:0] src_codes;

	// Only two byte lanes carry register bits, the upper lanes are ignored
	function automatic logic [IPLR_REG_W-1:0] apply_write(
		input logic [IPLR_REG_W-1:0] old_val,
		input logic [31:0] wdata,
		input logic [3:0] strb,
		input logic [IPLR_REG_W-1:0] mask
	);
		logic [IPLR_REG_W-1:0] lane_mask;
		lane_mask = {{8{strb[1]}}, {8{strb[0]}}} & mask;
		apply_write = (old_val & ~lane_mask) | (wdata[IPLR_REG_W-1:0] & lane_mask);
	endfunction

	// Enable and level a code must reach arbitration with, one cycle later
	function automatic logic [2:0] expect_src(input logic [1:0] code);
		expect_src = (code == IPLR_CODE_MASKED) ? 3'h0 : {1'b1, 2'(code - IPLR_CODE_LEVEL0)};
	endfunction

	iplr_apb_decode #(
		.ADDR_W(ADDR_W)
	) u_decode (
		.i_paddr(i_paddr),
		.o_sel_reg6(sel_reg6),
		.o_sel_reg7(sel_reg7),
		.o_sel_reg8(sel_reg8),
		.o_sel_reg9(sel_reg9),
		.o_mapped(mapped)
	);

	always_comb begin
		setup_phase = i_psel & ~i_penable;
		access_phase = i_psel & i_penable;
		wr_en = access_phase & i_pwrite;
		// No wait states, unmapped addresses answer with an error
		o_pready = 1'b1;
		o_pslverr = access_phase & ~mapped;
		o_prdata = prdata_ff;
	end

	// Register writes
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			reg6_ff <= IPLR_RESET_VAL;
		end else if (wr_en && sel_reg6) begin
			reg6_ff <= apply_write(reg6_ff, i_pwdata, i_pstrb, IPLR_MASK_REG6);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			priority_reg_timers_ab_c_ff <= IPLR_RESET_VAL;
		end else if (wr_en && sel_reg7) begin
			priority_reg_timers_ab_c_ff <= apply_write(priority_reg_timers_ab_c_ff,
				i_pwdata, i_pstrb, IPLR_MASK_REG7);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			priority_reg_serial0_timer_a_ff <= IPLR_RESET_VAL;
		end else if (wr_en && sel_reg8) begin
			// Reserved pair masked off so it can never hold a one
			priority_reg_serial0_timer_a_ff <= apply_write(priority_reg_serial0_timer_a_ff,
				i_pwdata, i_pstrb, IPLR_MASK_REG8);
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			priority_reg_pwm_converter_ff <= IPLR_RESET_VAL;
		end else if (wr_en && sel_reg9) begin
			priority_reg_pwm_converter_ff <= apply_write(priority_reg_pwm_converter_ff,
				i_pwdata, i_pstrb, IPLR_MASK_REG9);
		end
	end

	// Read path
	always_comb begin
		rd_value = '0;
		if (sel_reg6) begin
			rd_value = reg6_ff & IPLR_MASK_REG6;
		end else if (sel_reg7) begin
			rd_value = priority_reg_timers_ab_c_ff;
		end else if (sel_reg8) begin
			rd_value = priority_reg_serial0_timer_a_ff & IPLR_MASK_REG8;
		end else if (sel_reg9) begin
			rd_value = priority_reg_pwm_converter_ff;
		end
	end

	// Captured in setup, so a write just before is already visible
	always_ff @(posedge i_clk) begin
		if (i_sys_rst) begin
			prdata_ff <= '0;
		end else if (setup_phase) begin
			prdata_ff <= {{(32-IPLR_REG_W){1'b0}}, rd_value};
		end
	end

	// Field to source mapping
	always_comb begin
		src_codes = '0;
		src_codes[2*S_DECODER0_INDEX +: 2] = reg6_ff[F_DECODER0_INDEX_LEVEL +: 2];
		src_codes[2*S_DECODER0_HOME_WDOG +: 2] =
			reg6_ff[F_DECODER0_HOME_WDOG_LEVEL +: 2];
		src_codes[2*S_TIMER_A_CH0 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_A_CH0_LEVEL +: 2];
		src_codes[2*S_TIMER_B_CH3 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_B_CH3_LEVEL +: 2];
		src_codes[2*S_TIMER_B_CH2 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_B_CH2_LEVEL +: 2];
		src_codes[2*S_TIMER_B_CH1 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_B_CH1_LEVEL +: 2];
		src_codes[2*S_TIMER_B_CH0 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_B_CH0_LEVEL +: 2];
		src_codes[2*S_TIMER_C_CH3 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_C_CH3_LEVEL +: 2];
		src_codes[2*S_TIMER_C_CH2 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_C_CH2_LEVEL +: 2];
		src_codes[2*S_TIMER_C_CH1 +: 2] =
			priority_reg_timers_ab_c_ff[F_TIMER_C_CH1_LEVEL +: 2];
		src_codes[2*S_SERIAL0_RX_FULL +: 2] =
			priority_reg_serial0_timer_a_ff[F_SERIAL0_RX_FULL_LEVEL +: 2];
		src_codes[2*S_SERIAL0_RX_ERROR +: 2] =
			priority_reg_serial0_timer_a_ff[F_SERIAL0_RX_ERROR_LEVEL +: 2];
		src_codes[2*S_SERIAL0_TX_IDLE +: 2] =
			priority_reg_serial0_timer_a_ff[F_SERIAL0_TX_IDLE_LEVEL +: 2];
		src_codes[2*S_SERIAL0_TX_EMPTY +: 2] =
			priority_reg_serial0_timer_a_ff[F_SERIAL0_TX_EMPTY_LEVEL +: 2];
		src_codes[2*S_TIMER_A_CH3 +: 2] =
			priority_reg_serial0_timer_a_ff[F_TIMER_A_CH3_LEVEL +: 2];
		src_codes[2*S_TIMER_A_CH2 +: 2] =
			priority_reg_serial0_timer_a_ff[F_TIMER_A_CH2_LEVEL +: 2];
		src_codes[2*S_TIMER_A_CH1 +: 2] =
			priority_reg_serial0_timer_a_ff[F_TIMER_A_CH1_LEVEL +: 2];
		src_codes[2*S_PWM_A_FAULT +: 2] =
			priority_reg_pwm_converter_ff[F_PWM_A_FAULT_LEVEL +: 2];
		src_codes[2*S_PWM_B_FAULT +: 2] =
			priority_reg_pwm_converter_ff[F_PWM_B_FAULT_LEVEL +: 2];
		src_codes[2*S_PWM_A_RELOAD +: 2] =
			priority_reg_pwm_converter_ff[F_PWM_A_RELOAD_LEVEL +: 2];
		src_codes[2*S_PWM_B_RELOAD +: 2] =
			priority_reg_pwm_converter_ff[F_PWM_B_RELOAD_LEVEL +: 2];
		src_codes[2*S_CONV_A_ZERO_CROSS +: 2] =
			priority_reg_pwm_converter_ff[F_CONV_A_ZERO_CROSS_LEVEL +: 2];
		src_codes[2*S_CONV_B_ZERO_CROSS +: 2] =
			priority_reg_pwm_converter_ff[F_CONV_B_ZERO_CROSS_LEVEL +: 2];
		src_codes[2*S_CONV_A_COMPLETE +: 2] =
			priority_reg_pwm_converter_ff[F_CONV_A_COMPLETE_LEVEL +: 2];
		src_codes[2*S_CONV_B_COMPLETE +: 2] =
			priority_reg_pwm_converter_ff[F_CONV_B_COMPLETE_LEVEL +: 2];
	end

	iplr_level_decode #(
		.NUM_SRC(IPLR_NUM_SRC)
	) u_level (
		.i_clk(i_clk),
		.i_sys_rst(i_sys_rst),
		.i_codes(src_codes),
		.o_req_en(o_src_req_en),
		.o_level(o_src_level)
	);

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);

	sequence full_write(logic sel);
		access_phase && i_pwrite && sel && i_pstrb[1:0] == 2'b11;
	endsequence

	sequence read_access;
		access_phase && !i_pwrite && mapped;
	endsequence

	chk_reset_masked: assert property (
		$fell(i_sys_rst) |-> reg6_ff == IPLR_RESET_VAL && o_src_req_en == '0 &&
		priority_reg_timers_ab_c_ff == IPLR_RESET_VAL &&
		priority_reg_serial0_timer_a_ff == IPLR_RESET_VAL &&
		priority_reg_pwm_converter_ff == IPLR_RESET_VAL)
		else $error("priority field not masked after reset");

	chk_reserved_zero: assert property (
		full_write(sel_reg8) |=> priority_reg_serial0_timer_a_ff[F_REG8_RESERVED +: 2] == 2'h0)
		else $error("reserved pair of eighth register took a write");

	chk_reg6_fields: assert property (
		full_write(sel_reg6) |=> reg6_ff == ($past(i_pwdata[IPLR_REG_W-1:0]) & IPLR_MASK_REG6))
		else $error("sixth register low fields not written as expected");

	chk_write_whole: assert property (
		full_write(sel_reg7) |=> priority_reg_timers_ab_c_ff == $past(i_pwdata[IPLR_REG_W-1:0]))
		else $error("write did not update every field at once");

	chk_read_back: assert property (
		read_access |-> o_pready && !o_pslverr && o_prdata == {16'h0000, rd_value})
		else $error("read did not return the current field values");

	chk_timer_b_path: assert property (
		full_write(sel_reg7) ##1 1'b1 |=>
		o_src_level[2*S_TIMER_B_CH3 +: 2] == 2'($past(i_pwdata[13:12], 2) - IPLR_CODE_LEVEL0) ||
		$past(i_pwdata[13:12], 2) == IPLR_CODE_MASKED)
		else $error("timer B channel 3 level not taken from bits 13-12");

	chk_unmapped_err: assert property (
		access_phase && !mapped |-> o_pslverr && o_pready)
		else $error("unmapped access answered without error");

	// Reserved pair must read zero even if the flop were ever corrupted
	chk_reserved_read: assert property (
		access_phase && !i_pwrite && sel_reg8 |-> o_prdata[F_REG8_RESERVED +: 2] == 2'h0)
		else $error("reserved pair of eighth register read back nonzero");

	// Each path below catches a field wired to the wrong source slot
	chk_decoder_path: assert property (
		1'b1 |=> {o_src_req_en[S_DECODER0_INDEX], o_src_level[2*S_DECODER0_INDEX +: 2]} ==
		expect_src($past(reg6_ff[F_DECODER0_INDEX_LEVEL +: 2])))
		else $error("decoder index source not driven from its field");

	chk_timer_a0_path: assert property (
		1'b1 |=> {o_src_req_en[S_TIMER_A_CH0], o_src_level[2*S_TIMER_A_CH0 +: 2]} ==
		expect_src($past(priority_reg_timers_ab_c_ff[F_TIMER_A_CH0_LEVEL +: 2])))
		else $error("timer A channel 0 source not driven from its field");

	chk_timer_c3_path: assert property (
		1'b1 |=> {o_src_req_en[S_TIMER_C_CH3], o_src_level[2*S_TIMER_C_CH3 +: 2]} ==
		expect_src($past(priority_reg_timers_ab_c_ff[F_TIMER_C_CH3_LEVEL +: 2])))
		else $error("timer C channel 3 source not driven from its field");

	chk_rx_full_path: assert property (
		1'b1 |=> {o_src_req_en[S_SERIAL0_RX_FULL], o_src_level[2*S_SERIAL0_RX_FULL +: 2]} ==
		expect_src($past(priority_reg_serial0_timer_a_ff[F_SERIAL0_RX_FULL_LEVEL +: 2])))
		else $error("serial receive full source not driven from its field");

	chk_tx_idle_path: assert property (
		1'b1 |=> {o_src_req_en[S_SERIAL0_TX_IDLE], o_src_level[2*S_SERIAL0_TX_IDLE +: 2]} ==
		expect_src($past(priority_reg_serial0_timer_a_ff[F_SERIAL0_TX_IDLE_LEVEL +: 2])))
		else $error("serial transmit idle source not driven from its field");

	chk_timer_a2_path: assert property (
		1'b1 |=> {o_src_req_en[S_TIMER_A_CH2], o_src_level[2*S_TIMER_A_CH2 +: 2]} ==
		expect_src($past(priority_reg_serial0_timer_a_ff[F_TIMER_A_CH2_LEVEL +: 2])))
		else $error("timer A channel 2 source not driven from its field");

	chk_pwm_fault_path: assert property (
		1'b1 |=> {o_src_req_en[S_PWM_A_FAULT], o_src_level[2*S_PWM_A_FAULT +: 2]} ==
		expect_src($past(priority_reg_pwm_converter_ff[F_PWM_A_FAULT_LEVEL +: 2])))
		else $error("PWM A fault source not driven from its field");

	chk_pwm_reload_path: assert property (
		1'b1 |=> {o_src_req_en[S_PWM_B_RELOAD], o_src_level[2*S_PWM_B_RELOAD +: 2]} ==
		expect_src($past(priority_reg_pwm_converter_ff[F_PWM_B_RELOAD_LEVEL +: 2])))
		else $error("PWM B reload source not driven from its field");

	chk_conv_path: assert property (
		1'b1 |=> {o_src_req_en[S_CONV_B_COMPLETE], o_src_level[2*S_CONV_B_COMPLETE +: 2]} ==
		expect_src($past(priority_reg_pwm_converter_ff[F_CONV_B_COMPLETE_LEVEL +: 2])))
		else $error("converter B complete source not driven from its field");

endmodule
